// *** logic/lpms_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// RQ1 - Wait: keep run setup except detector off, sleep CPU, interrupt resumes
// RQ2 - Stop: static, detector off, interrupt resumes
// RQ3 - Leak three retains everything, leak two keeps partial SRAM per RQ4; wake-up interrupt resumes
// RQ4 - Partial levels keep 16 or 32 KB
// RQ5 - Deep three retains all; wake-up reset
// RQ6 - Deep one/zero: SRAM off, register file on
// RQ7 - Deep one and below gate radio logic
// RQ8 - Deep zero only with converter in bypass
// RQ9 - Zero with brown-out: analog, oscillator off; pins
// RQ10 - Zero without brown-out: also detector off
// RQ11 - Radio retention keeps 32 kHz deep sleep
// RQ12 - Continuous converter in wait/stop disables biasing
// RQ13 - Sleep request: wait or stop by select
// RQ14 - Software field selects stop level applied

module lpms_sequencer (
  input  wire logic                CLOCK,         // 10 MHz system clock
  input  wire logic                SYS_RST,       // Synchronous reset, active high
  input  wire logic                SLEEP_REQ,     // Wait-for-interrupt pulse
  input  wire logic                DEEP_SEL,      // Deep sleep select bit
  input  wire lpms_pkg::lpms_sel_t STOP_SEL,      // Software stop level field
  input  wire logic                PART_SIZE,     // Partial RAM size, 1 keeps 32 KB
  input  wire logic                DCDC_BYPASS,   // Converter in bypass configuration
  input  wire logic                DCDC_CONT,     // Converter in continuous mode
  input  wire lpms_pkg::lpms_wake_t WAKE,         // Wake sources
  input  wire logic                RF_WE,         // Register file write strobe
  input  wire logic [4:0]          RF_ADDR,       // Register file byte index
  input  wire logic [7:0]          RF_WDATA,      // Register file write byte
  output logic      [7:0]          RF_RDATA,      // Register file read byte
  output lpms_pkg::lpms_pwr_t      PWR,           // Power and retention controls
  output lpms_pkg::lpms_rcv_t      RCV,           // Recovery pulses
  output lpms_pkg::lpms_mode_t     MODE,          // Current mode
  output logic                     REQ_REFUSED    // Pulse: deep zero refused
);

  import lpms_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    lpms_mode_t mode;
    lpms_pwr_t  pwr;
    lpms_rcv_t  rcv;
    logic       part32;
    logic       refused;
    logic [2:0] rst_cnt;
  } lpms_st_t;

  lpms_st_t st_q;
  lpms_st_t st_d;

  // Wake reset length must fit the three-bit down counter
  if (LPMS_WRST_CYC < 1 || LPMS_WRST_CYC > 8) begin : g_bad_wrst
    $error("lpms_sequencer: wake reset count out of range");
  end

  // Control set for each mode
  function automatic lpms_pwr_t pwr_of(lpms_mode_t m, logic part32, logic cont);
    lpms_pwr_t p;
    p = LPMS_PWR_RUN;
    unique case (m)
      LPMS_RUN, LPMS_WAKE_RESET: begin
        p = LPMS_PWR_RUN;
      end
      LPMS_VLP_WAIT: begin
        p.cpu_sleep = 1'b1;                                   // RQ1
        p.lvd_en    = 1'b0;
        p.bias_en   = !cont;                                  // RQ12
      end
      LPMS_VLP_STOP: begin
        p.cpu_sleep = 1'b1;                                   // RQ2
        p.lvd_en    = 1'b0;                                   // RQ2
        p.bias_en   = !cont;                                  // RQ12
        p.io_hold   = 1'b1;
      end
      LPMS_LEAK_THREE, LPMS_LEAK_TWO, LPMS_DEEP_THREE, LPMS_DEEP_TWO: begin
        p.cpu_sleep    = 1'b1;
        p.lvd_en       = 1'b0;
        p.bias_en      = 1'b0;
        p.io_hold      = 1'b1;
        p.wkup_unit_en = 1'b1;                                // RQ3
        p.radio_retain = 1'b1;                                // RQ3
        p.dsm_clk_en   = 1'b1;                                // RQ11
        if (m == LPMS_LEAK_TWO || m == LPMS_DEEP_TWO) begin
          p.sram_hi_pwr = part32;                             // RQ4
        end
      end
      LPMS_DEEP_ONE, LPMS_DEEP_ZERO, LPMS_DEEP_ZNB: begin
        p.cpu_sleep    = 1'b1;
        p.lvd_en       = 1'b0;
        p.bias_en      = 1'b0;
        p.io_hold      = 1'b1;
        p.sram_hi_pwr  = 1'b0;                                // RQ6
        p.sram_lo_pwr  = 1'b0;                                // RQ6
        p.regfile_pwr  = 1'b1;                                // RQ6
        p.radio_pwr    = 1'b0;                                // RQ7
        p.dsm_clk_en   = 1'b0;                                // RQ7
        p.wkup_unit_en = (m == LPMS_DEEP_ONE);
        if (m != LPMS_DEEP_ONE) begin
          p.pmc_analog_en = 1'b0;                             // RQ9
          p.lpo_en        = 1'b0;                             // RQ9
          p.periph_en     = 1'b0;                             // RQ9
          p.bod_en        = (m == LPMS_DEEP_ZERO);            // RQ10
        end
      end
    endcase
    return p;
  endfunction

  // Stop level chosen by the software field
  function automatic lpms_mode_t stop_of(lpms_sel_t s);
    lpms_mode_t m;
    m = LPMS_VLP_STOP;
    unique case (s)
      LPMS_SEL_VLP_STOP:   m = LPMS_VLP_STOP;
      LPMS_SEL_LEAK_THREE: m = LPMS_LEAK_THREE;
      LPMS_SEL_LEAK_TWO:   m = LPMS_LEAK_TWO;
      LPMS_SEL_DEEP_THREE: m = LPMS_DEEP_THREE;
      LPMS_SEL_DEEP_TWO:   m = LPMS_DEEP_TWO;
      LPMS_SEL_DEEP_ONE:   m = LPMS_DEEP_ONE;
      LPMS_SEL_DEEP_ZERO:  m = LPMS_DEEP_ZERO;
      LPMS_SEL_DEEP_ZNB:   m = LPMS_DEEP_ZNB;
    endcase
    return m;
  endfunction

  logic       rf_pwr;
  lpms_mode_t target;
  logic       zero_sel;

  assign target   = stop_of(STOP_SEL);
  assign zero_sel = (target == LPMS_DEEP_ZERO) || (target == LPMS_DEEP_ZNB);
  assign rf_pwr   = st_q.pwr.regfile_pwr;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_d         = st_q;
    st_d.rcv     = '0;
    st_d.refused = 1'b0;
    unique case (st_q.mode)
      LPMS_RUN: begin
        if (SLEEP_REQ) begin
          if (!DEEP_SEL) begin
            st_d.mode = LPMS_VLP_WAIT;                        // RQ13
          end else if (zero_sel && !DCDC_BYPASS) begin
            st_d.refused = 1'b1;                              // RQ8
          end else begin
            st_d.mode   = target;                             // RQ13 RQ14
            st_d.part32 = PART_SIZE;                          // RQ4
          end
        end
      end
      LPMS_VLP_WAIT, LPMS_VLP_STOP: begin
        if (WAKE.irq || WAKE.pin_irq) begin
          st_d.mode           = LPMS_RUN;                     // RQ1 RQ2
          st_d.rcv.cpu_resume = 1'b1;
        end
      end
      LPMS_LEAK_THREE, LPMS_LEAK_TWO: begin
        if (WAKE.wkup_irq || WAKE.pin_irq) begin
          st_d.mode         = LPMS_RUN;                       // RQ3
          st_d.rcv.wkup_int = 1'b1;
        end
      end
      LPMS_DEEP_THREE, LPMS_DEEP_TWO, LPMS_DEEP_ONE: begin
        if (WAKE.wkup_irq || WAKE.pin_irq) begin
          st_d.mode    = LPMS_WAKE_RESET;                     // RQ5
          st_d.rst_cnt = 3'(LPMS_WRST_CYC - 1);
        end
      end
      LPMS_DEEP_ZERO, LPMS_DEEP_ZNB: begin
        if (WAKE.pin_irq) begin
          st_d.mode    = LPMS_WAKE_RESET;                     // RQ9 RQ10
          st_d.rst_cnt = 3'(LPMS_WRST_CYC - 1);
        end
      end
      LPMS_WAKE_RESET: begin
        st_d.rcv.wkup_rst = 1'b1;                             // RQ5
        if (st_q.rst_cnt == 3'h0) begin
          st_d.mode = LPMS_RUN;
        end else begin
          st_d.rst_cnt = st_q.rst_cnt - 3'h1;
        end
      end
      default: begin
        st_d.mode = LPMS_RUN;
      end
    endcase
    st_d.pwr = pwr_of(st_d.mode, st_d.part32, DCDC_CONT);
  end

  // State register
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      st_q.mode    <= LPMS_RUN;
      st_q.pwr     <= LPMS_PWR_RUN;
      st_q.rcv     <= '0;
      st_q.part32  <= LPMS_PART_16K;
      st_q.refused <= 1'b0;
      st_q.rst_cnt <= 3'h0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Retained register file
  // ---------------------------------------------------------------------------
  lpms_regfile #(
    .DEPTH (LPMS_REGFILE_B),
    .AW    (5)
  ) u_regfile (
    .clk   (CLOCK),
    .pwr   (rf_pwr),                                          // RQ6
    .we    (RF_WE),
    .addr  (RF_ADDR),
    .wdata (RF_WDATA),
    .rdata (RF_RDATA)
  );

  assign PWR         = st_q.pwr;
  assign RCV         = st_q.rcv;
  assign MODE        = st_q.mode;
  assign REQ_REFUSED = st_q.refused;

endmodule // lpms_sequencer

`default_nettype wire

// *** logic/lpms_pkg.sv ***
`default_nettype none

package lpms_pkg;

  // ---------------------------------------------------------------------------
  // Stop level selection codes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    LPMS_SEL_VLP_STOP   = 3'h0,
    LPMS_SEL_LEAK_THREE = 3'h1,
    LPMS_SEL_LEAK_TWO   = 3'h2,
    LPMS_SEL_DEEP_THREE = 3'h3,
    LPMS_SEL_DEEP_TWO   = 3'h4,
    LPMS_SEL_DEEP_ONE   = 3'h5,
    LPMS_SEL_DEEP_ZERO  = 3'h6,
    LPMS_SEL_DEEP_ZNB   = 3'h7
  } lpms_sel_t;

  // ---------------------------------------------------------------------------
  // Mode held by the sequencer
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    LPMS_RUN,
    LPMS_VLP_WAIT,
    LPMS_VLP_STOP,
    LPMS_LEAK_THREE,
    LPMS_LEAK_TWO,
    LPMS_DEEP_THREE,
    LPMS_DEEP_TWO,
    LPMS_DEEP_ONE,
    LPMS_DEEP_ZERO,
    LPMS_DEEP_ZNB,
    LPMS_WAKE_RESET
  } lpms_mode_t;

  // Power and retention controls, all active high
  typedef struct packed {
    logic cpu_sleep;
    logic lvd_en;
    logic bias_en;
    logic sram_hi_pwr;
    logic sram_lo_pwr;
    logic regfile_pwr;
    logic radio_retain;
    logic radio_pwr;
    logic dsm_clk_en;
    logic pmc_analog_en;
    logic lpo_en;
    logic bod_en;
    logic io_hold;
    logic wkup_unit_en;
    logic periph_en;
  } lpms_pwr_t;

  // Wake sources
  typedef struct packed {
    logic irq;
    logic wkup_irq;
    logic pin_irq;
  } lpms_wake_t;

  // Recovery indications
  typedef struct packed {
    logic cpu_resume;
    logic wkup_int;
    logic wkup_rst;
  } lpms_rcv_t;

  // Partial RAM size choice: 0 keeps 16 KB, 1 keeps 32 KB
  localparam logic       LPMS_PART_16K  = 1'b0;
  localparam logic       LPMS_PART_32K  = 1'b1;
  localparam int         LPMS_REGFILE_B = 32;
  localparam int         LPMS_WRST_CYC  = 4;
  localparam lpms_pwr_t  LPMS_PWR_RUN   = '{cpu_sleep: 1'b0, lvd_en: 1'b1, bias_en: 1'b1,
    sram_hi_pwr: 1'b1, sram_lo_pwr: 1'b1, regfile_pwr: 1'b1, radio_retain: 1'b0,
    radio_pwr: 1'b1, dsm_clk_en: 1'b1, pmc_analog_en: 1'b1, lpo_en: 1'b1, bod_en: 1'b1,
    io_hold: 1'b0, wkup_unit_en: 1'b0, periph_en: 1'b1};

endpackage : lpms_pkg

`default_nettype wire

// *** logic/lpms_regfile.sv ***
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------------------
// Retained system register file, read data registered
// -----------------------------------------------------------------------------
module lpms_regfile #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          clk,    // System clock
  input  wire logic          pwr,    // Power present, contents kept while high
  input  wire logic          we,     // Write strobe
  input  wire logic [AW-1:0] addr,   // Byte index
  input  wire logic [7:0]    wdata,  // Write byte
  output logic      [7:0]    rdata   // Registered read byte
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0]            rd;
  } lpms_rf_st_t;

  lpms_rf_st_t st_q;
  lpms_rf_st_t st_d;

  // Refuse a depth that the index cannot address exactly
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("lpms_regfile: DEPTH must be 2**AW");
  end

  // Write and read port
  always_comb begin
    st_d = st_q;
    if (pwr && we) begin
      st_d.mem[addr] = wdata;
    end
    st_d.rd = st_q.mem[addr];
  end

  // State register; no reset so contents survive a wake-up reset
  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  assign rdata = st_q.rd;

endmodule // lpms_regfile

`default_nettype wire

// *** test/lpms_sequencer_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------
// Mode and power checks at the sequencer ports
// ---------------------------------------------
module lpms_sq_chk
  import lpms_pkg::*;
(
  input wire logic       CLOCK,       // Clock
  input wire logic       SYS_RST,     // Reset
  input wire logic       SLEEP_REQ,   // Sleep pulse
  input wire logic       DEEP_SEL,    // Stop select
  input wire lpms_sel_t  STOP_SEL,    // Level field
  input wire logic       DCDC_BYPASS, // Bypass
  input wire logic       DCDC_CONT,   // Continuous
  input wire lpms_wake_t WAKE,        // Wake sources
  input wire lpms_pwr_t  PWR,         // Controls
  input wire lpms_rcv_t  RCV,         // Recovery
  input wire lpms_mode_t MODE,        // Mode
  input wire logic       REQ_REFUSED  // Refusal
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  wire req = MODE == LPMS_RUN && SLEEP_REQ;

  AST_WAIT_ENTRY: assert property (req && !DEEP_SEL |=> MODE == LPMS_VLP_WAIT && PWR.cpu_sleep)
    else $error("wait not entered");
  AST_STOP_ENTRY: assert property (req && DEEP_SEL && (STOP_SEL < 3'h6 || DCDC_BYPASS)
    |=> MODE == lpms_mode_t'({1'b0, $past(STOP_SEL)} + 4'h2))
    else $error("wrong stop level");
  AST_REFUSE: assert property (req && DEEP_SEL && STOP_SEL >= 3'h6 && !DCDC_BYPASS
    |=> REQ_REFUSED && MODE == LPMS_RUN)
    else $error("deep zero not refused");
  AST_VERY_LOW_POWER_STOP_LVD: assert property (MODE == LPMS_VLP_STOP |-> !PWR.lvd_en)
    else $error("detector on in stop");
  AST_BIAS: assert property (MODE inside {LPMS_VLP_WAIT, LPMS_VLP_STOP} && DCDC_CONT
    && $past(DCDC_CONT) |-> !PWR.bias_en)
    else $error("bias on");
  AST_LEAK_WAKE: assert property (MODE inside {LPMS_LEAK_THREE, LPMS_LEAK_TWO}
    && WAKE.pin_irq |=> MODE == LPMS_RUN && RCV.wkup_int)
    else $error("leak wake wrong");
  AST_DEEP_RESET: assert property (MODE == LPMS_DEEP_THREE && WAKE.pin_irq
    |=> MODE == LPMS_WAKE_RESET ##1 RCV.wkup_rst [*4] ##1 !RCV.wkup_rst)
    else $error("wake reset wrong");
  AST_DEEP_GATE: assert property (MODE inside {LPMS_DEEP_ONE, LPMS_DEEP_ZERO, LPMS_DEEP_ZNB}
    |-> !PWR.sram_hi_pwr && !PWR.sram_lo_pwr && PWR.regfile_pwr && !PWR.radio_pwr)
    else $error("deep gating wrong");
  AST_RETAIN: assert property (MODE inside {LPMS_LEAK_THREE, LPMS_LEAK_TWO,
    LPMS_DEEP_THREE, LPMS_DEEP_TWO} |-> PWR.radio_retain && PWR.dsm_clk_en)
    else $error("radio retention off");
  AST_ZERO: assert property (MODE inside {LPMS_DEEP_ZERO, LPMS_DEEP_ZNB}
    |-> !PWR.lpo_en && !PWR.pmc_analog_en && PWR.io_hold
    && PWR.bod_en == (MODE == LPMS_DEEP_ZERO))
    else $error("deep zero controls wrong");

  COV_WAIT: cover property (req && !DEEP_SEL);
  COV_RESET: cover property (MODE == LPMS_WAKE_RESET);
  COV_REFUSE: cover property (REQ_REFUSED);
endmodule // lpms_sq_chk

bind lpms_sequencer lpms_sq_chk i_lpms_sq_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .SLEEP_REQ(SLEEP_REQ), .DEEP_SEL(DEEP_SEL), .STOP_SEL(STOP_SEL), .DCDC_BYPASS(DCDC_BYPASS),
  .DCDC_CONT(DCDC_CONT), .WAKE(WAKE), .PWR(PWR), .RCV(RCV), .MODE(MODE),
  .REQ_REFUSED(REQ_REFUSED));
`default_nettype wire

// *** test/lpms_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end

// ---------------------------------------------
// Directed bench for the sequencer
// ---------------------------------------------
module lpms_sequencer_tb;
  import lpms_pkg::*;
  logic clk = 0, rst = 1, req = 0, deep = 0, part = 0, byp = 1, cont = 0, we = 0;
  lpms_sel_t  sel = LPMS_SEL_VLP_STOP;
  lpms_wake_t wake = '0;
  logic [4:0] addr = '0;
  logic [7:0] wdata = '0, rdata;
  lpms_pwr_t  pwr;
  lpms_rcv_t  rcv;
  lpms_mode_t mode;
  logic       refused;
  int failures = 0, n_checks = 0;

  always #50 clk = ~clk;

  lpms_sequencer i_lpms_sequencer (.CLOCK(clk), .SYS_RST(rst), .SLEEP_REQ(req),
    .DEEP_SEL(deep), .STOP_SEL(sel), .PART_SIZE(part), .DCDC_BYPASS(byp), .DCDC_CONT(cont),
    .WAKE(wake), .RF_WE(we), .RF_ADDR(addr), .RF_WDATA(wdata), .RF_RDATA(rdata), .PWR(pwr),
    .RCV(rcv), .MODE(mode), .REQ_REFUSED(refused));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask

  // One-cycle request; returns when the new mode shows
  task automatic sleep(logic d, lpms_sel_t s);
    req = 1; deep = d; sel = s; tick(1); req = 0;
  endtask

  task automatic wake_up(logic [2:0] w);
    wake = lpms_wake_t'(w); tick(1); wake = '0;
  endtask

  // Bounded wait for run, counting wake reset cycles
  task automatic to_run(output int k);
    k = 0;
    for (int i = 0; i < 20 && mode !== LPMS_RUN; i++) begin
      tick(1);
      if (rcv.wkup_rst === 1'b1) k++;
    end
    if (mode !== LPMS_RUN) begin failures++; finish_test(); end
  endtask

  task automatic t_wait();
    cont = 1;
    sleep(0, LPMS_SEL_DEEP_ONE);
    `CHK(mode, LPMS_VLP_WAIT)
    `CHK(pwr.cpu_sleep, 1'b1)
    `CHK(pwr.bias_en, 1'b0)
    wake_up(3'b100);
    `CHK(rcv.cpu_resume, 1'b1)
    sleep(1, LPMS_SEL_VLP_STOP);
    `CHK(mode, LPMS_VLP_STOP)
    `CHK(pwr.bias_en, 1'b0)
    `CHK(pwr.lvd_en, 1'b0)
    wake_up(3'b100);
    `CHK(rcv.cpu_resume, 1'b1)
    cont = 0;
    $display("t_wait done");
  endtask

  task automatic t_refuse();
    byp = 0;
    for (int i = 6; i < 8; i++) begin
      sleep(1, lpms_sel_t'(i));
      `CHK(refused, 1'b1)
      `CHK(mode, LPMS_RUN)
      tick(1);
    end
    byp = 1;
    $display("t_refuse done");
  endtask

  // Every level with both partial sizes
  task automatic t_levels();
    logic [7:0] hi = 8'h0b, lo = 8'h1f, ret = 8'h1e, unit = 8'h3e, per = 8'h3f;
    int k;
    for (int p = 0; p < 2; p++) for (int i = 0; i < 8; i++) begin
      part = p[0];
      sleep(1, lpms_sel_t'(i));
      `CHK(mode, lpms_mode_t'(i + 2))
      `CHK(pwr.sram_hi_pwr, hi[i] | (p[0] & (i == 2 || i == 4)))
      `CHK(pwr.sram_lo_pwr, lo[i])
      `CHK(pwr.radio_pwr, lo[i])
      `CHK(pwr.radio_retain, ret[i])
      `CHK(pwr.wkup_unit_en, unit[i])
      `CHK(pwr.periph_en, per[i])
      `CHK(pwr.bias_en, i == 0)
      if (i >= 6) `CHK(pwr.bod_en, i == 6)
      if (i >= 1) begin
        wake_up(i >= 6 ? 3'b110 : 3'b100);
        `CHK(mode, lpms_mode_t'(i + 2))
        tick(1);
      end
      wake_up(3'b001);
      if (i == 0) `CHK(rcv.cpu_resume, 1'b1)
      else if (i < 3) `CHK(rcv.wkup_int, 1'b1)
      else begin
        `CHK(mode, LPMS_WAKE_RESET)
        to_run(k);
        `CHK(k, LPMS_WRST_CYC)
      end
    end
    $display("t_levels done");
  endtask

  // Reset while in a retention level, then a request at the first edge after release
  task automatic t_reset();
    part = 1;
    sleep(1, LPMS_SEL_DEEP_TWO);
    `CHK(mode, LPMS_DEEP_TWO)
    rst = 1;
    tick(2);
    rst = 0;
    `CHK(mode, LPMS_RUN)
    `CHK(pwr, LPMS_PWR_RUN)
    `CHK(rcv, 3'h0)
    `CHK(refused, 1'b0)
    sleep(0, LPMS_SEL_VLP_STOP);
    `CHK(mode, LPMS_VLP_WAIT)
    wake_up(3'b001);
    `CHK(rcv.cpu_resume, 1'b1)
    part = 0;
    $display("t_reset done");
  endtask

  task automatic t_regfile();
    int k;
    we = 1; addr = 5'h1f; wdata = 8'ha5; tick(1); we = 0;
    sleep(1, LPMS_SEL_DEEP_ONE);
    wake_up(3'b001);
    to_run(k);
    tick(1);
    `CHK(rdata, 8'ha5)
    $display("t_regfile done");
  endtask

  initial begin
    tick(12);
    rst = 0;
    tick(1);
    `CHK(pwr, LPMS_PWR_RUN)
    t_wait();
    t_refuse();
    t_levels();
    t_reset();
    t_regfile();
    finish_test();
  end
endmodule // lpms_sequencer_tb
`default_nettype wire
